// ---- core/alu_pkg.sv ----
package alu_pkg;

    // ----------------------------------------------------------------
    // operations handed over by the sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        op_none,
        sub_acc_from_file,
        rotate_right_through_carry,
        nibble_exchange,
        pin_direction_load,
        xor_literal_into_acc,
        xor_acc_with_file
    } op_e;

    // one decoded instruction from the sequencer
    typedef struct packed
    {
        op_e op;
        logic [4:0] file_idx;
        logic dest;
        logic [7:0] literal;
    } instr_s;

    // status flags kept by the datapath
    typedef struct packed
    {
        logic carry;
        logic half_carry_bit;
        logic zero;
    } flags_s;

    // combinational answer of the arithmetic unit
    typedef struct packed
    {
        logic [7:0] result;
        flags_s flags;
        logic upd_carry;
        logic upd_half;
        logic upd_zero;
        logic wr_acc;
        logic wr_file;
        logic wr_dir;
    } alu_out_s;

    // all state of the top module
    typedef struct packed
    {
        logic [7:0] acc;
        flags_s flags;
        logic [7:0] dir6;
        logic [7:0] dir7;
        logic [31:0][7:0] file;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } state_s;

    // ----------------------------------------------------------------
    // register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ACC_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DIR6_OFFSET = 8'h08;
    localparam logic [7:0] DIR7_OFFSET = 8'h0C;
    localparam int FILE_WINDOW_BIT = 7;

    // status field positions
    localparam int STAT_CARRY_BIT = 0;
    localparam int STAT_HALF_BIT = 1;
    localparam int STAT_ZERO_BIT = 2;

    // direction register selectors
    localparam logic [4:0] DIR6_INDEX = 5'h06;
    localparam logic [4:0] DIR7_INDEX = 5'h07;

    // reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] FILE_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic FLAG_RESET = 1'b0;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // zero test shared by several operations
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

endpackage

// ---- core/alu_core.sv ----
`timescale 1ns/1ns
module alu_core
(
    input wire alu_pkg::instr_s instr, // decoded instruction
    input wire logic [7:0] acc, // accumulator value
    input wire logic [7:0] fval, // addressed file register
    input wire alu_pkg::flags_s flags, // current flags
    output alu_pkg::alu_out_s res // result and write enables
);

    // ----------------------------------------------------------------
    // operation decode and arithmetic
    // ----------------------------------------------------------------
    logic [8:0] diff;
    logic [4:0] low_diff;

    // subtraction as f + ~w + 1 so carry means no borrow
    assign diff = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
    assign low_diff = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

    always_comb
    begin
        res = '0;
        res.flags = flags;
        case (instr.op)
            // [RULE_01] file minus accumulator
            alu_pkg::sub_acc_from_file:
            begin
                res.result = diff[7:0];
                res.flags.carry = diff[8];
                res.flags.half_carry_bit = low_diff[4];
                res.upd_carry = 1'b1;
                res.upd_half = 1'b1;
                res.upd_zero = 1'b1;
            end
            // [RULE_03] old carry into bit 7
            alu_pkg::rotate_right_through_carry:
            begin
                res.result = {flags.carry, fval[7:1]};
                res.flags.carry = fval[0];
                res.upd_carry = 1'b1;
            end
            // [RULE_04] swap nibbles, flags kept
            alu_pkg::nibble_exchange:
            begin
                res.result = {fval[3:0], fval[7:4]};
            end
            // [RULE_05] accumulator to direction
            alu_pkg::pin_direction_load:
            begin
                res.result = acc;
                res.wr_dir = 1'b1;
            end
            // [RULE_06] literal xor into accumulator
            alu_pkg::xor_literal_into_acc:
            begin
                res.result = acc ^ instr.literal;
                res.upd_zero = 1'b1;
            end
            // [RULE_07] xor with file register
            alu_pkg::xor_acc_with_file:
            begin
                res.result = acc ^ fval;
                res.upd_zero = 1'b1;
            end
            default:
            begin
                res.result = 8'h00;
            end
        endcase
        // [RULE_08] zero flag from result
        if (res.upd_zero)
        begin
            res.flags.zero = alu_pkg::is_zero(res.result);
        end
        // [RULE_02] destination select routing
        if (instr.op != alu_pkg::op_none && instr.op != alu_pkg::pin_direction_load
            && instr.op != alu_pkg::xor_literal_into_acc)
        begin
            res.wr_file = instr.dest;
            res.wr_acc = ~instr.dest;
        end
        else if (instr.op == alu_pkg::xor_literal_into_acc)
        begin
            res.wr_acc = 1'b1;
        end
    end

endmodule

// ---- core/byte_alu_subset_ops.sv ----
// Contract
// [RULE_01] subtract-from-file computes file minus accumulator, updates carry, half carry, zero
// [RULE_02] destination bit 0 writes accumulator, 1 writes back the file register
// [RULE_03] rotate right through carry; old carry into bit 7; only carry changes
// [RULE_04] nibble swap exchanges upper and lower halves; flags untouched
// [RULE_05] direction load copies accumulator into direction register 6 or 7; flags untouched
// [RULE_06] literal xor puts accumulator xor literal into accumulator; only zero changes
// [RULE_07] file xor routes accumulator xor file by destination; only zero changes
// [RULE_08] affected zero flag is set exactly when the eight-bit result is zero
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
module byte_alu_subset_ops
(
    input wire logic hclk, // core clock, 125 MHz
    input wire logic hresetn, // async reset, active low
    input wire logic exec_valid, // one instruction this cycle
    input wire alu_pkg::instr_s exec_instr, // decoded instruction
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response
    output logic [31:0] hrdata, // ahb read data
    output logic [7:0] acc_q, // accumulator
    output alu_pkg::flags_s flags_q, // status flags
    output logic [7:0] dir6_q, // direction register 6
    output logic [7:0] dir7_q // direction register 7
);

    // ----------------------------------------------------------------
    // state and datapath
    // ----------------------------------------------------------------
    alu_pkg::state_s st_ff;
    alu_pkg::state_s nxt_st;
    alu_pkg::instr_s live_instr;
    alu_pkg::alu_out_s alu_res;
    logic [7:0] fval;
    // bus request qualified this cycle; read data is held in the state struct
    logic bus_take;

    // an idle slot runs as no operation so nothing is written
    always_comb
    begin
        live_instr = exec_instr;
        if (!exec_valid)
        begin
            live_instr.op = alu_pkg::op_none;
        end
    end

    // file operand read straight from the register array, no extra cycle
    assign fval = st_ff.file[exec_instr.file_idx];

    // purely combinational arithmetic; results land through nxt_st
    alu_core u_alu
    (
        .instr(live_instr),
        .acc(st_ff.acc),
        .fval(fval),
        .flags(st_ff.flags),
        .res(alu_res)
    );

    // size is ignored: only whole-word singles are used on this slave
    assign bus_take = hsel & hready & (htrans == alu_pkg::HTRANS_NONSEQ);

    // ----------------------------------------------------------------
    // address decode shared by the read and write paths
    // ----------------------------------------------------------------
    // the upper half of the byte map is the file window
    function automatic logic in_file_window(input logic [7:0] a);
        in_file_window = a[alu_pkg::FILE_WINDOW_BIT];
    endfunction

    // word index inside the file window; byte lanes are ignored
    function automatic logic [4:0] file_slot(input logic [7:0] a);
        file_slot = a[6:2];
    endfunction

    // a direction load only lands in the register that it names
    function automatic logic dir_hit(input alu_pkg::alu_out_s r, input logic [4:0] idx, input logic [4:0] sel);
        dir_hit = r.wr_dir && (idx == sel);
    endfunction

    // ----------------------------------------------------------------
    // read mux for the bus
    // ----------------------------------------------------------------
    function automatic logic [31:0] read_word(input alu_pkg::state_s s, input logic [7:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        if (in_file_window(a))
        begin
            w[7:0] = s.file[file_slot(a)];
        end
        else
        begin
            case (a)
                alu_pkg::ACC_OFFSET: w[7:0] = s.acc;
                alu_pkg::STATUS_OFFSET:
                begin
                    w[alu_pkg::STAT_CARRY_BIT] = s.flags.carry;
                    w[alu_pkg::STAT_HALF_BIT] = s.flags.half_carry_bit;
                    w[alu_pkg::STAT_ZERO_BIT] = s.flags.zero;
                end
                alu_pkg::DIR6_OFFSET: w[7:0] = s.dir6;
                alu_pkg::DIR7_OFFSET: w[7:0] = s.dir7;
                default: w = 32'h00000000;
            endcase
        end
        read_word = w;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // bus writes land first so an instruction in the same cycle wins;
    // software racing the sequencer on one register loses by design
    always_comb
    begin
        nxt_st = st_ff;
        if (st_ff.wr_pend)
        begin
            if (in_file_window(st_ff.wr_addr))
            begin
                nxt_st.file[file_slot(st_ff.wr_addr)] = hwdata[7:0];
            end
            else
            begin
                case (st_ff.wr_addr)
                    alu_pkg::ACC_OFFSET: nxt_st.acc = hwdata[7:0];
                    alu_pkg::STATUS_OFFSET:
                    begin
                        nxt_st.flags.carry = hwdata[alu_pkg::STAT_CARRY_BIT];
                        nxt_st.flags.half_carry_bit = hwdata[alu_pkg::STAT_HALF_BIT];
                        nxt_st.flags.zero = hwdata[alu_pkg::STAT_ZERO_BIT];
                    end
                    default: nxt_st.acc = nxt_st.acc;
                endcase
            end
        end
        // address phase captured; read data prepared for the data phase
        nxt_st.wr_pend = bus_take & hwrite;
        nxt_st.wr_addr = haddr[7:0];
        if (bus_take && !hwrite)
        begin
            nxt_st.rdata = read_word(st_ff, haddr[7:0]);
        end
        // instruction results below override any bus write above
        // [RULE_02] result routed by destination
        if (alu_res.wr_acc)
        begin
            nxt_st.acc = alu_res.result;
        end
        if (alu_res.wr_file)
        begin
            nxt_st.file[exec_instr.file_idx] = alu_res.result;
        end
        // [RULE_05] only registers 6 and 7 accept
        if (dir_hit(alu_res, exec_instr.file_idx, alu_pkg::DIR6_INDEX))
        begin
            nxt_st.dir6 = alu_res.result;
        end
        if (dir_hit(alu_res, exec_instr.file_idx, alu_pkg::DIR7_INDEX))
        begin
            nxt_st.dir7 = alu_res.result;
        end
        // [RULE_01] [RULE_03] flags of the subtraction and the carry of the rotate
        if (alu_res.upd_carry)
        begin
            nxt_st.flags.carry = alu_res.flags.carry;
        end
        if (alu_res.upd_half)
        begin
            nxt_st.flags.half_carry_bit = alu_res.flags.half_carry_bit;
        end
        // [RULE_08] zero flag where affected
        if (alu_res.upd_zero)
        begin
            nxt_st.flags.zero = alu_res.flags.zero;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // file registers clear on reset so early reads never show unknowns
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_ff.acc <= alu_pkg::ACC_RESET;
            st_ff.flags.carry <= alu_pkg::FLAG_RESET;
            st_ff.flags.half_carry_bit <= alu_pkg::FLAG_RESET;
            st_ff.flags.zero <= alu_pkg::FLAG_RESET;
            st_ff.dir6 <= alu_pkg::DIR_RESET;
            st_ff.dir7 <= alu_pkg::DIR_RESET;
            st_ff.file <= {32{alu_pkg::FILE_RESET}};
            st_ff.wr_pend <= 1'b0;
            st_ff.wr_addr <= 8'h00;
            st_ff.rdata <= 32'h00000000;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero wait states, so the slave never holds the bus
    assign hreadyout = 1'b1;
    assign hresp = alu_pkg::HRESP_OKAY;
    assign hrdata = st_ff.rdata;
    assign acc_q = st_ff.acc;
    assign flags_q = st_ff.flags;
    assign dir6_q = st_ff.dir6;
    assign dir7_q = st_ff.dir7;

endmodule

// ---- sim/seq_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// instruction sequencer stand-in
// ----------------------------------------
module seq_model
(
    input wire logic hclk, // core clock
    input wire logic hresetn, // active low reset
    input wire logic issue, // bench asks for one slot
    input wire alu_pkg::instr_s issue_instr, // instruction to hand over
    output logic exec_valid, // slot valid
    output alu_pkg::instr_s exec_instr // slot content
);
    // idle slots carry scrambled fields so the design cannot lean on stale ones
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            exec_valid <= 1'b0;
            exec_instr <= '0;
        end
        else
        begin
            exec_valid <= issue;
            exec_instr <= issue ? issue_instr : ~exec_instr;
        end
    end
endmodule

// ---- sim/alu_ops_checker.sv ----
`timescale 1ns/1ns
// ----------------------------------------
// datapath property checks
// ----------------------------------------
module alu_ops_checker
(
    input wire logic hclk, // core clock
    input wire logic hresetn, // active low reset
    input wire logic exec_valid, // slot valid
    input wire alu_pkg::instr_s exec_instr, // instruction
    input wire logic [7:0] acc_q, // accumulator
    input wire alu_pkg::flags_s flags_q, // flags
    input wire logic [7:0] dir6_q, // direction 6
    input wire logic [7:0] dir7_q // direction 7
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic go_sub, go_rot, go_swp, go_dir, go_xl, go_xf;
    // decoded strobes keep the properties short
    assign go_sub = exec_valid && exec_instr.op == alu_pkg::sub_acc_from_file;
    assign go_rot = exec_valid && exec_instr.op == alu_pkg::rotate_right_through_carry;
    assign go_swp = exec_valid && exec_instr.op == alu_pkg::nibble_exchange;
    assign go_dir = exec_valid && exec_instr.op == alu_pkg::pin_direction_load;
    assign go_xl = exec_valid && exec_instr.op == alu_pkg::xor_literal_into_acc;
    assign go_xf = exec_valid && exec_instr.op == alu_pkg::xor_acc_with_file;
    property p_sub;
        go_sub && !exec_instr.dest |=> !flags_q.zero || (flags_q.carry && flags_q.half_carry_bit);
    endproperty
    a_sub: assert property (p_sub) else $error("equal operands must give no borrow");
    property p_dest;
        (go_sub || go_rot || go_swp || go_xf) && exec_instr.dest |=> $stable(acc_q);
    endproperty
    a_dest: assert property (p_dest) else $error("file destination touched acc");
    property p_rot;
        go_rot && !exec_instr.dest |=> acc_q[7] == $past(flags_q.carry) && $stable(flags_q.zero);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate msb not old carry");
    property p_swap;
        go_swp |=> $stable(flags_q);
    endproperty
    a_swap: assert property (p_swap) else $error("swap changed flags");
    property p_dir;
        go_dir && exec_instr.file_idx == alu_pkg::DIR6_INDEX
            |=> dir6_q == $past(acc_q) && $stable(dir7_q) && $stable(flags_q);
    endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong");
    property p_dir7;
        go_dir && exec_instr.file_idx == alu_pkg::DIR7_INDEX
            |=> dir7_q == $past(acc_q) && $stable(dir6_q) && $stable(flags_q);
    endproperty
    a_dir7: assert property (p_dir7) else $error("direction 7 load wrong");
    property p_xlit;
        go_xl |=> acc_q == $past(acc_q ^ exec_instr.literal);
    endproperty
    a_xlit: assert property (p_xlit) else $error("literal xor result wrong");
    property p_xkeep;
        go_xl || go_xf |=> $stable(flags_q.carry) && $stable(flags_q.half_carry_bit);
    endproperty
    a_xkeep: assert property (p_xkeep) else $error("xor changed carry flags");
    property p_zero;
        go_xl || ((go_sub || go_xf) && !exec_instr.dest) |=> flags_q.zero == (acc_q == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag mismatch");
endmodule
bind byte_alu_subset_ops alu_ops_checker i_alu_ops_checker
(
    .hclk(hclk),
    .hresetn(hresetn),
    .exec_valid(exec_valid),
    .exec_instr(exec_instr),
    .acc_q(acc_q),
    .flags_q(flags_q),
    .dir6_q(dir6_q),
    .dir7_q(dir7_q)
);

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic issue = 1'b0;
    alu_pkg::instr_s issue_instr = '0;
    alu_pkg::instr_s exec_instr;
    alu_pkg::instr_s ins;
    alu_pkg::flags_s flags_q;
    alu_pkg::flags_s fl_m = '0;
    logic exec_valid, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, r, seed = 32'hBBFC;
    logic [7:0] acc_q, dir6_q, dir7_q, acc_m = 8'h00, d6_m = 8'hFF, d7_m = 8'hFF;
    logic [7:0] file_m [32] = '{default: 8'h00};
    int errors = 0, total_checks = 0, cycles = 0;
    always #4 hclk = ~hclk;
    seq_model i_seq_model (.hclk(hclk), .hresetn(hresetn), .issue(issue), .issue_instr(issue_instr),
        .exec_valid(exec_valid), .exec_instr(exec_instr));
    // hsize fixed to a word: only whole-word transfers are used
    byte_alu_subset_ops i_byte_alu_subset_ops (.hclk(hclk), .hresetn(hresetn), .exec_valid(exec_valid),
        .exec_instr(exec_instr), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .acc_q(acc_q), .flags_q(flags_q), .dir6_q(dir6_q), .dir7_q(dir7_q));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // reference model of one instruction
    function automatic void ref_exec(input alu_pkg::instr_s i);
        logic [7:0] f;
        logic [7:0] v;
        f = file_m[i.file_idx];
        v = f ^ acc_m;
        case (i.op)
            alu_pkg::sub_acc_from_file:
            begin
                v = f - acc_m;
                fl_m.carry = f >= acc_m;
                fl_m.half_carry_bit = f[3:0] >= acc_m[3:0];
            end
            alu_pkg::rotate_right_through_carry:
            begin
                v = {fl_m.carry, f[7:1]};
                fl_m.carry = f[0];
            end
            alu_pkg::nibble_exchange: v = {f[3:0], f[7:4]};
            alu_pkg::xor_literal_into_acc: v = acc_m ^ i.literal;
            alu_pkg::pin_direction_load:
            begin
                if (i.file_idx == alu_pkg::DIR6_INDEX) d6_m = acc_m;
                if (i.file_idx == alu_pkg::DIR7_INDEX) d7_m = acc_m;
            end
            default: ;
        endcase
        if (i.op inside {alu_pkg::sub_acc_from_file, alu_pkg::xor_literal_into_acc, alu_pkg::xor_acc_with_file})
            fl_m.zero = (v == 8'h00);
        if (i.op != alu_pkg::op_none && i.op != alu_pkg::pin_direction_load)
        begin
            if (i.dest && i.op != alu_pkg::xor_literal_into_acc) file_m[i.file_idx] = v;
            else acc_m = v;
        end
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single ahb transfer; holds each phase until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= alu_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic exec(input alu_pkg::instr_s i);
        @(posedge hclk);
        issue <= 1'b1;
        issue_instr <= i;
        ref_exec(i);
    endtask
    // close a burst, then compare all visible state and the touched file register
    task automatic settle_chk(input logic [4:0] idx);
        @(posedge hclk);
        issue <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        chk(32'(acc_q), 32'(acc_m));
        chk(32'(flags_q), 32'(fl_m));
        chk({16'(dir6_q), 16'(dir7_q)}, {16'(d6_m), 16'(d7_m)});
        bus(1'b0, 8'h80 + {idx, 2'b00}, 32'h0, rd);
        chk(rd, 32'(file_m[idx]));
        // the accumulator, status and direction 7 read mux entries and the response line
        bus(1'b0, alu_pkg::ACC_OFFSET, 32'h0, rd);
        chk(rd, 32'(acc_m));
        chk(32'(hresp), 32'(alu_pkg::HRESP_OKAY));
        bus(1'b0, alu_pkg::STATUS_OFFSET, 32'h0, rd);
        chk(rd, {29'h0, fl_m.zero, fl_m.half_carry_bit, fl_m.carry});
        bus(1'b0, alu_pkg::DIR7_OFFSET, 32'h0, rd);
        chk(rd, 32'(d7_m));
    endtask
    task automatic stop_test();
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            stop_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, read-only and unmapped places
        bus(1'b1, 8'h08, 32'h12, rd);
        bus(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'(alu_pkg::DIR_RESET));
        bus(1'b1, 8'h40, 32'hAB, rd);
        bus(1'b0, 8'h40, 32'h0, rd);
        chk(rd, 32'h0);
        for (int n = 0; n < 32; n++)
        begin
            r = xs();
            file_m[n] = r[7:0];
            bus(1'b1, 8'h80 + 8'(4 * n), {24'h0, r[7:0]}, rd);
        end
        // equal operands: result zero with no borrow, then back-to-back literal xors
        acc_m = file_m[31];
        bus(1'b1, 8'h00, 32'(acc_m), rd);
        exec('{alu_pkg::sub_acc_from_file, 5'h1F, 1'b0, 8'h00});
        exec('{alu_pkg::xor_literal_into_acc, 5'h00, 1'b0, 8'hFF});
        exec('{alu_pkg::xor_literal_into_acc, 5'h00, 1'b1, 8'hFF});
        settle_chk(5'd31);
        for (int k = 0; k < 300; k++)
        begin
            r = xs();
            ins.op = alu_pkg::op_e'((r[2:0] == 3'h7) ? 3'h0 : r[2:0]);
            ins.file_idx = (ins.op == alu_pkg::pin_direction_load && r[3]) ? {4'h3, r[4]} : r[12:8];
            ins.dest = r[13];
            ins.literal = r[23:16];
            exec(ins);
            if (r[26])
            begin
                settle_chk(ins.file_idx);
                bus(1'b1, 8'h04, {29'h0, r[30:28]}, rd);
                fl_m = {r[28], r[29], r[30]};
            end
        end
        settle_chk(ins.file_idx);
        stop_test();
    end
endmodule
